/* core/rtcpc_defs.svh */
// constants of the periodic and run control block of the rtc
// assumes a 125 mhz ref_clk and a 32.768 khz crystal level on a pin
`ifndef RTCPC_DEFS_SVH
`define RTCPC_DEFS_SVH
`define RTCPC_AW 4
`define RTCPC_A_CTRL 4'h0
`define RTCPC_A_STAT 4'h1
`define RTCPC_A_MASK 4'h2
`define RTCPC_A_C64 4'h3
`define RTCPC_CTRL_POR 8'h09
`define RTCPC_B_PFLAG 7
`define RTCPC_B_SEL_HI 6
`define RTCPC_B_SEL_LO 4
`define RTCPC_B_OSC 3
`define RTCPC_B_ADJ 2
`define RTCPC_B_DRST 1
`define RTCPC_B_RUN 0
`define RTCPC_EV_PER 0
`define RTCPC_EV_SEC 1
`define RTCPC_PRE_LAST 9'h01ff
`define RTCPC_PRE_Q256 7'h7f
`define RTCPC_C64_LAST 6'h3f
`define RTCPC_C64_Q16 2'h3
`define RTCPC_C64_Q4 4'hf
`define RTCPC_C64_Q2 5'h1f
`define RTCPC_SEC_HALF 8'h30
`endif

/* core/rtcpc_pkg.sv */
// types of the periodic and run control block
// assumes rtcpc_defs.svh is on the include path
package rtcpc_pkg;
  typedef enum logic [2:0] {
    SEL_OFF, SEL_256, SEL_64, SEL_16, SEL_4, SEL_2, SEL_1, SEL_HALF
  } rtcpc_sel_t;

  typedef struct packed {
    logic xs1;
    logic xs2;
    logic xs3;
    logic [8:0] pre;
    logic [5:0] c64;
    logic two_s;
    logic pflag;
    rtcpc_sel_t sel;
    logic osc_en;
    logic run;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic sec_tick;
    logic sec_clr;
    logic min_adv;
    logic div_clr;
  } rtcpc_state_t;
endpackage

/* core/rtcpc_ctrl.sv */
// periodic flag, oscillator enable, rounding, divider reset and run control
// assumes a single 125 mhz clock, register port on the same clock, crystal on a pin
// What this block does
// - power-on reset loads the control register with 0x09.
// - manual reset clears control bits except oscillator enable and run.
// - standby blocks control writes; only a period tick can still set the periodic flag.
// - periodic flag sets on period or written one, clears on written zero.
// - periodic interrupt request is high while the periodic flag is one.
// - period select: off, 1/256, 1/64, 1/16, 1/4, 1/2, 1, 2 seconds.
// - oscillator enable zero stops the crystal, one lets it run.
// - writing one to rounding zeroes seconds, advancing minutes from thirty.
// - the rounding write also clears prescaler and 64 hz counter.
// - rounding and divider reset act on written one, always read zero.
// - writing one to divider reset clears prescaler and 64 hz counter.
// - run bit zero halts second to year counters, one lets them count.
// - 64 hz counter ignores run bit, stops only with the oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "rtcpc_defs.svh"

module rtcpc_ctrl
  import rtcpc_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic standby,
  // register port
  input wire logic [`RTCPC_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // crystal side
  input wire logic xtal_in,
  output logic oscillator_enable,
  // time counters outside
  input wire logic [7:0] seconds_bcd,
  output logic count_run,
  output logic sec_tick,
  output logic sec_clear,
  output logic min_advance,
  output logic divider_clear,
  output logic [5:0] sixty_four_hz_counter,
  // interrupts
  output logic periodic_irq,
  output logic irq
);

  rtcpc_state_t s_r;
  rtcpc_state_t s_nxt;

  // one helper for every period choice so the taps stay in one place
  function automatic logic period_hit(input rtcpc_sel_t sel,
                                      input logic [8:0] pre,
                                      input logic [5:0] c64,
                                      input logic two_s);
    logic pw;
    pw = (pre == `RTCPC_PRE_LAST);
    case (sel)
      SEL_256: period_hit = (pre[6:0] == `RTCPC_PRE_Q256);
      SEL_64: period_hit = pw;
      SEL_16: period_hit = pw && (c64[1:0] == `RTCPC_C64_Q16);
      SEL_4: period_hit = pw && (c64[3:0] == `RTCPC_C64_Q4);
      SEL_2: period_hit = pw && (c64[4:0] == `RTCPC_C64_Q2);
      SEL_1: period_hit = pw && (c64 == `RTCPC_C64_LAST);
      SEL_HALF: period_hit = pw && (c64 == `RTCPC_C64_LAST) && two_s;
      default: period_hit = 1'b0;
    endcase
  endfunction

  logic xt_edge;
  logic wr_ctrl;
  logic rd_stat;
  logic do_adj;
  logic do_drst;
  logic div_reset;
  logic period_tick;
  logic one_hz;

  always_comb begin
    // first sync stage is read by the second stage only
    xt_edge = s_r.xs2 && !s_r.xs3 && s_r.osc_en;
    // no register writes or status read-clears while asleep, so standby alone changes nothing
    wr_ctrl = reg_wr && !standby && (reg_addr == `RTCPC_A_CTRL);
    rd_stat = reg_rd && !standby && (reg_addr == `RTCPC_A_STAT);
    do_adj = wr_ctrl && reg_wdata[`RTCPC_B_ADJ];
    do_drst = wr_ctrl && reg_wdata[`RTCPC_B_DRST];
    div_reset = do_adj || do_drst;
    // a divider clear swallows a coincident crystal edge, phase restarts
    period_tick = xt_edge && !div_reset
                  && period_hit(s_r.sel, s_r.pre, s_r.c64, s_r.two_s);
    one_hz = xt_edge && !div_reset && (s_r.pre == `RTCPC_PRE_LAST)
             && (s_r.c64 == `RTCPC_C64_LAST);

    s_nxt = s_r;
    s_nxt.xs1 = xtal_in;
    s_nxt.xs2 = s_r.xs1;
    s_nxt.xs3 = s_r.xs2;

    // divider chain
    if (div_reset) begin
      s_nxt.pre = '0;
      s_nxt.c64 = '0;
      s_nxt.two_s = 1'b0;
    end else if (xt_edge) begin
      s_nxt.pre = s_r.pre + 9'h0001;
      if (s_r.pre == `RTCPC_PRE_LAST) begin
        s_nxt.c64 = s_r.c64 + 6'h01;
        if (s_r.c64 == `RTCPC_C64_LAST) begin
          s_nxt.two_s = !s_r.two_s;
        end
      end
    end

    // time counter strobes
    s_nxt.sec_tick = one_hz && s_r.run;
    s_nxt.sec_clr = do_adj;
    s_nxt.min_adv = do_adj && (seconds_bcd >= `RTCPC_SEC_HALF);
    s_nxt.div_clr = div_reset;

    // control register, a period tick beats a written zero
    if (wr_ctrl) begin
      s_nxt.pflag = reg_wdata[`RTCPC_B_PFLAG];
      s_nxt.sel = rtcpc_sel_t'(reg_wdata[`RTCPC_B_SEL_HI:`RTCPC_B_SEL_LO]);
      s_nxt.osc_en = reg_wdata[`RTCPC_B_OSC];
      s_nxt.run = reg_wdata[`RTCPC_B_RUN];
    end
    if (period_tick) begin
      s_nxt.pflag = 1'b1;
    end

    // mask register and read-clear status, events win over the clear
    if (reg_wr && !standby && (reg_addr == `RTCPC_A_MASK)) begin
      s_nxt.mask = reg_wdata[1:0];
    end
    if (rd_stat) begin
      s_nxt.stat = 2'h0;
    end
    if (period_tick) begin
      s_nxt.stat[`RTCPC_EV_PER] = 1'b1;
    end
    if (s_nxt.sec_tick) begin
      s_nxt.stat[`RTCPC_EV_SEC] = 1'b1;
    end

    // read data, self-clearing bits always read zero
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RTCPC_A_CTRL: s_nxt.rdata = {s_r.pflag, s_r.sel, s_r.osc_en,
                                      2'b00, s_r.run};
        `RTCPC_A_STAT: s_nxt.rdata = {6'h00, s_r.stat};
        `RTCPC_A_MASK: s_nxt.rdata = {6'h00, s_r.mask};
        `RTCPC_A_C64: s_nxt.rdata = {2'b00, s_r.c64};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // manual reset keeps oscillator and run, clears the rest
    if (manual_rst) begin
      s_nxt.pflag = 1'b0;
      s_nxt.sel = SEL_OFF;
      s_nxt.osc_en = s_r.osc_en;
      s_nxt.run = s_r.run;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.osc_en <= 1'(`RTCPC_CTRL_POR >> `RTCPC_B_OSC);
      s_r.run <= 1'(`RTCPC_CTRL_POR >> `RTCPC_B_RUN);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign oscillator_enable = s_r.osc_en;
  assign count_run = s_r.run;
  assign sec_tick = s_r.sec_tick;
  assign sec_clear = s_r.sec_clr;
  assign min_advance = s_r.min_adv;
  assign divider_clear = s_r.div_clr;
  assign sixty_four_hz_counter = s_r.c64;
  assign periodic_irq = s_r.pflag;
  // level irq: holds until the status read clears the unmasked bit or a mask write zeroes its mask bit
  assign irq = |(s_r.stat & s_r.mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (1'b0);

  sequence adj_write;
    reg_wr && !standby && (reg_addr == `RTCPC_A_CTRL) && reg_wdata[`RTCPC_B_ADJ];
  endsequence

  sequence adj_effect;
    sec_clear && divider_clear && (s_r.pre == 9'h0000) && (s_r.c64 == 6'h00);
  endsequence

  a_por_value: assert property (
      rst |=> (s_r.pflag == 1'b0) && (s_r.sel == SEL_OFF) && oscillator_enable && count_run)
    else $error("power-on value of control register wrong");

  a_manual_keep: assert property (disable iff (rst)
      manual_rst |=> (oscillator_enable == $past(oscillator_enable))
      && (count_run == $past(count_run)) && !periodic_irq && (s_r.sel == SEL_OFF))
    else $error("manual reset handled control bits wrong");

  a_standby_hold: assert property (disable iff (rst)
      (standby && !manual_rst) |=> $stable(s_r.sel) && $stable(s_r.osc_en)
      && $stable(s_r.run))
    else $error("control register changed in standby");

  a_flag_tick: assert property (disable iff (rst)
      (period_tick && !manual_rst) |=> periodic_irq ##1 (periodic_irq || $past(wr_ctrl)
      || $past(manual_rst)))
    else $error("periodic flag missed its period");

  a_flag_wzero: assert property (disable iff (rst)
      (wr_ctrl && !reg_wdata[`RTCPC_B_PFLAG] && !period_tick) |=> !periodic_irq)
    else $error("written zero did not clear periodic flag");

  a_sel_off: assert property (disable iff (rst)
      (s_r.sel == SEL_OFF) |-> !period_tick)
    else $error("period tick while period select is off");

  a_osc_stop: assert property (disable iff (rst)
      (!oscillator_enable && !div_reset) |=> $stable(s_r.pre) && $stable(s_r.c64))
    else $error("divider moved with oscillator stopped");

  a_adj_round: assert property (disable iff (rst)
      adj_write |=> (adj_effect
      and (min_advance == ($past(seconds_bcd) >= `RTCPC_SEC_HALF))))
    else $error("thirty second rounding wrong");

  a_ctrl_selfclr: assert property (disable iff (rst)
      (reg_rd && (reg_addr == `RTCPC_A_CTRL)) |=> (reg_rdata[2:1] == 2'b00)
      && (reg_rdata[0] == count_run || $past(wr_ctrl)))
    else $error("self-clearing bits read non-zero");

  a_div_reset: assert property (disable iff (rst)
      (wr_ctrl && reg_wdata[`RTCPC_B_DRST]) |=> divider_clear && (s_r.pre == 9'h0000)
      ##1 !divider_clear [*2])
    else $error("divider reset did not clear the chain");

  a_run_gate: assert property (disable iff (rst)
      !count_run |=> !sec_tick)
    else $error("second tick while counters halted");

  // a full second is out of reach in short runs, so the 64 hz step is watched instead
  a_c64_free: assert property (disable iff (rst)
      (xt_edge && !div_reset && (s_r.pre == `RTCPC_PRE_LAST) && !count_run)
      |=> (s_r.c64 == $past(s_r.c64) + 6'h01))
    else $error("64 hz counter stopped by run bit");

  a_tick_phase: assert property (disable iff (rst)
      div_reset |=> !period_tick [*8])
    else $error("periodic tick right after divider reset");

  a_pre_count: assert property (disable iff (rst)
      (xt_edge && !div_reset) |=> (s_r.pre == $past(s_r.pre) + 9'h001))
    else $error("prescaler missed a crystal edge");

  a_stat_period: assert property (disable iff (rst)
      period_tick |=> s_r.stat[`RTCPC_EV_PER])
    else $error("period status bit not set");

  a_stat_second: assert property (disable iff (rst)
      (one_hz && count_run) |=> sec_tick && s_r.stat[`RTCPC_EV_SEC])
    else $error("second tick or status missing");

  a_stat_rdclr: assert property (disable iff (rst)
      (rd_stat && !period_tick && !(one_hz && count_run)) |=> (s_r.stat == 2'h0))
    else $error("status read did not clear");

  a_irq_masked: assert property (disable iff (rst)
      (s_r.mask == 2'h0) |-> !irq)
    else $error("irq raised with all events masked");

  a_rdata_idle: assert property (disable iff (rst)
      !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data stood without a read");

  a_tick_pulse: assert property (disable iff (rst)
      sec_tick |=> !sec_tick)
    else $error("second tick longer than one cycle");

  a_min_pair: assert property (disable iff (rst)
      min_advance |-> sec_clear)
    else $error("minute advance without seconds clear");

  a_flag_standby: assert property (disable iff (rst)
      (standby && !manual_rst && !period_tick) |=> $stable(periodic_irq))
    else $error("periodic flag changed in standby");

  a_mask_standby: assert property (disable iff (rst)
      standby |=> $stable(s_r.mask))
    else $error("mask changed in standby");

endmodule // rtcpc_ctrl

`default_nettype wire

/* tb/rtc_periodic_and_run_control_tb_top.sv */
// self-checking bench of the periodic and run control block
// assumes the package and constants header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "rtcpc_defs.svh"
module rtc_periodic_and_run_control_tb_top
  import rtcpc_pkg::*;
;
  logic ref_clk = 0, rst = 1, manual_rst = 0, standby = 0;
  logic reg_wr = 0, reg_rd = 0, xtal_in = 0, xon = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, seconds_bcd = 8'h00, rd_v, d;
  logic [7:0] reg_rdata;
  logic [5:0] c64;
  logic oscillator_enable, count_run, sec_tick, sec_clear;
  logic min_advance, divider_clear, periodic_irq, irq;
  logic [1:0] ph = 2'h0;
  logic [7:0] secs [4] = '{8'h00, 8'h29, 8'h30, 8'h59};
  int n_errors = 0, n_compared = 0, cyc = 0, edges = 0, e0, k;
  int seed = 32'hc788;

  rtcpc_ctrl dut (.ref_clk(ref_clk), .rst(rst), .manual_rst(manual_rst),
    .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xtal_in(xtal_in),
    .oscillator_enable(oscillator_enable), .seconds_bcd(seconds_bcd),
    .count_run(count_run), .sec_tick(sec_tick), .sec_clear(sec_clear),
    .min_advance(min_advance), .divider_clear(divider_clear),
    .sixty_four_hz_counter(c64), .periodic_irq(periodic_irq), .irq(irq));

  always #4 ref_clk = ~ref_clk;

  // fast crystal stand-in, 8 cycle period, low while stopped
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors = n_errors + 1;
      test_done;
    end
    ph <= xon ? ph + 2'h1 : 2'h0;
    if (!xon) xtal_in <= 1'b0;
    else if (ph == 2'h3) begin
      xtal_in <= ~xtal_in;
      if (!xtal_in) edges <= edges + 1;
    end
  end

  function automatic int per_edges(input int s);
    return 128 << (2 * (s - 1)); // 32768 edges a second
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  // edges counted from the bench side, not from the block
  task automatic run_edges(input int n);
    e0 = edges;
    xon <= 1'b1;
    while (edges - e0 < n) @(posedge ref_clk);
    xon <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic period(input int s);
    wr(`RTCPC_A_MASK, {7'h00, s == 1});
    wr(`RTCPC_A_CTRL, {1'b0, s[2:0], 4'hb});
    e0 = edges;
    xon <= 1'b1;
    for (k = 0; k < 30000 && periodic_irq !== 1'b1; k++) @(posedge ref_clk) #1;
    xon <= 1'b0;
    chk(edges - e0, per_edges(s), "period length");
    chk(irq, s == 1, "masked irq");
    rd(`RTCPC_A_STAT);
    chk(rd_v, 8'h01, "period status");
    @(posedge ref_clk) #1;
    chk(irq, 1'b0, "irq after status read");
    wr(`RTCPC_A_CTRL, 8'h09);
    chk(periodic_irq, 1'b0, "flag written zero");
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`RTCPC_A_CTRL);
    chk(rd_v, `RTCPC_CTRL_POR, "ctrl after power-on");
    rd(4'h7);
    chk(rd_v, 8'h00, "unmapped read");
    $display("test reset done");
    // crystal held, so only written values matter here
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(`RTCPC_A_CTRL, d);
      rd(`RTCPC_A_CTRL);
      chk(rd_v, d & 8'hf9, "ctrl readback");
      chk(periodic_irq, d[7], "flag written");
      chk(oscillator_enable, d[3], "osc enable");
      chk(count_run, d[0], "run bit");
    end
    repeat (16) @(posedge ref_clk);
    standby <= 1'b1;
    wr(`RTCPC_A_CTRL, ~d);
    rd(`RTCPC_A_CTRL);
    chk(rd_v, d & 8'hf9, "standby keeps ctrl");
    @(posedge ref_clk) standby <= 1'b0;
    @(posedge ref_clk) manual_rst <= 1'b1;
    @(posedge ref_clk) manual_rst <= 1'b0;
    rd(`RTCPC_A_CTRL);
    chk(rd_v, d & 8'h09, "manual reset");
    $display("test ctrl register done");
    for (int s = 1; s <= 3; s++) period(s);
    $display("test periods done");
    wr(`RTCPC_A_CTRL, 8'h0a);
    run_edges(512);
    rd(`RTCPC_A_C64);
    chk(rd_v, 8'h01, "64 hz runs while halted");
    chk(c64, 6'h01, "64 hz port");
    chk(count_run, 1'b0, "counters halted");
    chk(sec_tick, 1'b0, "no second tick while halted");
    chk(periodic_irq, 1'b0, "select off");
    wr(`RTCPC_A_CTRL, 8'h00);
    run_edges(600);
    rd(`RTCPC_A_C64);
    chk(rd_v, 8'h01, "64 hz stopped by osc");
    $display("test divider done");
    foreach (secs[i]) begin
      @(posedge ref_clk) seconds_bcd <= secs[i];
      wr(`RTCPC_A_CTRL, 8'h0c);
      chk({sec_clear, divider_clear}, 2'b11, "rounding pulses");
      chk(min_advance, secs[i] >= 8'h30, "minute advance");
      rd(`RTCPC_A_C64);
      chk(rd_v, 8'h00, "rounding clears divider");
    end
    wr(`RTCPC_A_CTRL, 8'h0b);
    chk({sec_clear, divider_clear}, 2'b01, "divider reset pulse");
    $display("test rounding done");
    test_done;
  end
endmodule // rtc_periodic_and_run_control_tb_top
`default_nettype wire
